/* File: hw/vcml_defs.svh */
`ifndef VCML_DEFS_SVH
`define VCML_DEFS_SVH
// What this block does
// - Cancel key returns home unless editing
// - While editing, commit stores, cancel discards
// - Auto key cycles modes, commit activates
// - Hand key selects keypad jog mode
// - One-input: asserted drives to its input's end, else the other end
// - Bit picks open or close input
// - Two-input: move toward asserted end, else hold
// - Loop current maps linearly to target
// - Feedback current follows actual position
// - Fieldbus resets to node 1, 38400, 10s
// - Power mode only with capacitor backup
// - Power mode: power present opens
// - Override enable plus direction contact moves
// - Override beats every run mode
// - Default relays: closed, open, no-fault make
// - Relay thresholds and polarities are settings
// - Command field shows idle or detected in one-input mode, none otherwise
// - Motor flag and start counter
// - Count raw angle wraps through zero
// - Count stalls, keep last stall cycle
// - No backup module: capacitor levels zero

// ********************************************
// Timing
// ********************************************
`define VCML_CLK_MHZ    125
`define VCML_DEB_US     1000
`define VCML_DEB_CYC    (`VCML_DEB_US * `VCML_CLK_MHZ)
`define VCML_DEB_CW     17

// ********************************************
// Input vector layout
// ********************************************
`define VCML_IN_W       13
`define VCML_B_ESC      0
`define VCML_B_COMMIT   1
`define VCML_B_HAND     2
`define VCML_B_AUTO     3
`define VCML_B_KOPEN    4
`define VCML_B_KCLOSE   5
`define VCML_B_COPEN    6
`define VCML_B_CCLOSE   7
`define VCML_B_OEN      8
`define VCML_B_OOPEN    9
`define VCML_B_OCLOSE   10
`define VCML_B_PWR      11
`define VCML_B_NAV      12
`define VCML_KEY_W      6
`define VCML_IN_RST     13'h0700

// ********************************************
// Positions, currents, defaults
// ********************************************
`define VCML_PCT_OPEN   7'h64
`define VCML_PCT_SHUT   7'h00
`define VCML_MA4        12'h190
`define VCML_MA20       12'h7d0
`define VCML_MA_SPAN    18'h640
`define VCML_PCT_MUL    18'h64
`define VCML_FB_SHIFT   4
`define VCML_NODE_RST   8'h01
`define VCML_BAUD_RST   16'h9600
`define VCML_TMO_RST    8'h0a
`define VCML_CFG_W      18
`define VCML_CFG_RST    18'h00064
`define VCML_ANG_W      12
`define VCML_ANG_TOP    2'h3
`define VCML_ANG_BOT    2'h0
`endif

/* File: hw/vcml_pkg.sv */
package vcml_pkg;
  // Run modes, manual first so cycling skips it
  typedef enum logic [2:0] {
    VCML_MANUAL, VCML_ONE_IN, VCML_TWO_IN, VCML_LOOP,
    VCML_SERIAL, VCML_NETWORK, VCML_POWER_SW
  } vcml_mode_t;

  typedef enum logic [1:0] {VCML_HOME, VCML_BROWSE, VCML_EDIT} vcml_ui_t;

  typedef enum logic [1:0] {VCML_CMD_NONE, VCML_CMD_IDLE, VCML_CMD_ACT}
    vcml_cmd_t;

  typedef enum logic [1:0] {VCML_BK_NONE, VCML_BK_EPB, VCML_BK_EPBR,
    VCML_BK_RSV} vcml_bk_t;

  // Stored settings, high bits first in the edit word
  typedef struct packed {
    logic       fault_break;
    logic       shut_break;
    logic       open_break;
    logic       one_on_close;
    logic [6:0] shut_thr;
    logic [6:0] open_thr;
  } vcml_cfg_t;
endpackage

/* File: hw/vcml_if.sv */
`timescale 1ns/1ns
`include "vcml_defs.svh"
interface vcml_if;
  logic [`VCML_IN_W-1:0] raw;
  logic [`VCML_IN_W-1:0] clean;
  modport user (output raw, input clean);
  modport filt (input raw, output clean);
endinterface

/* File: hw/vcml_debounce.sv */
`timescale 1ns/1ns
`include "vcml_defs.svh"
module vcml_debounce #(
  parameter int unsigned CYC = `VCML_DEB_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  vcml_if.filt      bus
);
  localparam logic [`VCML_DEB_CW-1:0] LIM = `VCML_DEB_CW'(CYC - 1);

  typedef struct packed {
    logic [`VCML_IN_W-1:0]                    s1;
    logic [`VCML_IN_W-1:0]                    s2;
    logic [`VCML_IN_W-1:0]                    s3;
    logic [`VCML_IN_W-1:0]                    q;
    logic [`VCML_IN_W-1:0][`VCML_DEB_CW-1:0]  cnt;
  } vcml_deb_t;

  vcml_deb_t s_r;
  vcml_deb_t s_nxt;

  // ********************************************
  // Sync chain and stable-time filter
  // ********************************************
  // Only s2/s3 are looked at; s1 may be metastable
  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.s1 = bus.raw;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < `VCML_IN_W; i++)
    begin
      if (s_r.s2[i] != s_r.s3[i] || s_r.s3[i] == s_r.q[i])
        s_nxt.cnt[i] = '0;
      else if (s_r.cnt[i] == LIM)
      begin
        s_nxt.q[i]   = s_r.s3[i];
        s_nxt.cnt[i] = '0;
      end
      else
        s_nxt.cnt[i] = s_r.cnt[i] + 1'b1;
    end
  end

  // Contacts idle open, so active-low bits reset high
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_r <= '{s1: `VCML_IN_RST, s2: `VCML_IN_RST, s3: `VCML_IN_RST,
               q: `VCML_IN_RST, cnt: '0};
    else
      s_r <= s_nxt;
  end

  assign bus.clean = s_r.q;
endmodule

/* File: hw/vcml_top.sv */
`timescale 1ns/1ns
`include "vcml_defs.svh"
module vcml_top #(
  parameter int unsigned DEB_CYC = `VCML_DEB_CYC
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    cancel_key_i,
  input  wire logic                    commit_key_i,
  input  wire logic                    hand_mode_key_i,
  input  wire logic                    auto_key_i,
  input  wire logic                    nav_key_i,
  input  wire logic                    key_open_i,
  input  wire logic                    key_close_i,
  input  wire logic                    cmd_open_i,
  input  wire logic                    cmd_close_i,
  input  wire logic                    override_enable_contact_n_i,
  input  wire logic                    ovr_open_n_i,
  input  wire logic                    ovr_close_n_i,
  input  wire logic                    power_present_i,
  input  wire logic [1:0]              capacitor_backup_option_i,
  input  wire logic                    factory_restore_i,
  input  wire logic [`VCML_CFG_W-1:0]  edit_val_i,
  input  wire logic [11:0]             loop_cur_i,
  input  wire logic [6:0]              bus_tgt_i,
  input  wire logic [6:0]              pos_pct_i,
  input  wire logic                    fault_i,
  input  wire logic                    motor_on_i,
  input  wire logic [`VCML_ANG_W-1:0]  raw_magnet_angle_i,
  input  wire logic                    motor_stall_i,
  input  wire logic                    cycle_stall_i,
  input  wire logic [15:0]             cycle_num_i,
  input  wire logic [31:0]             cap_lvl_i,
  output logic [1:0]                   ui_state_o,
  output logic [2:0]                   disp_mode_o,
  output logic [2:0]                   run_mode_o,
  output logic [`VCML_CFG_W-1:0]       cfg_o,
  output logic [6:0]                   tgt_pct_o,
  output logic                         tgt_en_o,
  output logic                         jog_open_o,
  output logic                         jog_close_o,
  output logic [11:0]                  fb_cur_o,
  output logic                         open_rly_o,
  output logic                         shut_rly_o,
  output logic                         fault_rly_o,
  output logic [1:0]                   cmd_ind_o,
  output logic [7:0]                   node_addr_o,
  output logic [15:0]                  baud_o,
  output logic [7:0]                   timeout_s_o,
  output logic                         motor_energized_flag_o,
  output logic [15:0]                  motor_starts_o,
  output logic [15:0]                  wrap_crossing_count_o,
  output logic [15:0]                  motor_stall_count_o,
  output logic [15:0]                  cycle_stall_count_o,
  output logic [15:0]                  last_stall_cycle_o,
  output logic [31:0]                  cap_lvl_o
);
  typedef struct packed {
    vcml_pkg::vcml_ui_t        ui;
    vcml_pkg::vcml_mode_t      disp;
    vcml_pkg::vcml_mode_t      run;
    vcml_pkg::vcml_cfg_t       cfg;
    logic [`VCML_KEY_W-1:0]    prev;
    logic                      mot_prev;
    logic [`VCML_ANG_W-1:0]    ang_prev;
    logic                      ang_ok;
    logic [6:0]                tgt;
    logic                      tgt_en;
    logic                      jo;
    logic                      jc;
    logic [11:0]               fb;
    logic                      rly_open;
    logic                      rly_shut;
    logic                      rly_fault;
    vcml_pkg::vcml_cmd_t       cmd;
    logic [7:0]                node;
    logic [15:0]               baud;
    logic [7:0]                tmo;
    logic                      mot;
    logic [15:0]               starts;
    logic [15:0]               wraps;
    logic [15:0]               mstall;
    logic [15:0]               cstall;
    logic [15:0]               last;
    logic [31:0]               cap;
  } vcml_st_t;

  vcml_st_t s_r;
  vcml_st_t s_nxt;
  vcml_if   inp ();

  // ********************************************
  // Input conditioning
  // ********************************************
  assign inp.raw = {nav_key_i, power_present_i, ovr_close_n_i,
                    ovr_open_n_i, override_enable_contact_n_i,
                    cmd_close_i, cmd_open_i, key_close_i, key_open_i,
                    auto_key_i, hand_mode_key_i, commit_key_i,
                    cancel_key_i};

  vcml_debounce #(.CYC(DEB_CYC)) u_deb (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .bus       (inp.filt)
  );

  // Key presses are rising edges of the clean level; nav acts on its level while cancel is up
  logic [`VCML_KEY_W-1:0] press;
  logic                   nav_p;
  logic                   ovr_on;
  logic                   bk_on;
  logic                   one_act;
  assign press   = inp.clean[`VCML_KEY_W-1:0] & ~s_r.prev;
  assign nav_p   = inp.clean[`VCML_B_NAV] & ~s_r.prev[`VCML_B_ESC] &
                   ~press[`VCML_B_ESC];
  assign ovr_on  = ~inp.clean[`VCML_B_OEN];
  assign bk_on   = capacitor_backup_option_i != 2'(vcml_pkg::VCML_BK_NONE);
  assign one_act = s_r.cfg.one_on_close ? inp.clean[`VCML_B_CCLOSE]
                                        : inp.clean[`VCML_B_COPEN];

  // ********************************************
  // Helpers
  // ********************************************
  // Next automatic mode; power mode needs the backup module
  function automatic vcml_pkg::vcml_mode_t next_auto(
    input vcml_pkg::vcml_mode_t m,
    input logic                 bk
  );
    unique case (m)
      vcml_pkg::VCML_ONE_IN:   next_auto = vcml_pkg::VCML_TWO_IN;
      vcml_pkg::VCML_TWO_IN:   next_auto = vcml_pkg::VCML_LOOP;
      vcml_pkg::VCML_LOOP:     next_auto = vcml_pkg::VCML_SERIAL;
      vcml_pkg::VCML_SERIAL:   next_auto = vcml_pkg::VCML_NETWORK;
      vcml_pkg::VCML_NETWORK:  next_auto = bk ? vcml_pkg::VCML_POWER_SW
                                              : vcml_pkg::VCML_ONE_IN;
      default:                 next_auto = vcml_pkg::VCML_ONE_IN;
    endcase
  endfunction

  // Loop current in 10 uA steps to percent, clamped at both ends
  function automatic logic [6:0] loop_pct(input logic [11:0] c);
    logic [17:0] t;
    t = 18'h0;
    if (c <= `VCML_MA4)
      loop_pct = `VCML_PCT_SHUT;
    else if (c >= `VCML_MA20)
      loop_pct = `VCML_PCT_OPEN;
    else
    begin
      t = {6'h0, c - `VCML_MA4} * `VCML_PCT_MUL;
      loop_pct = 7'(t / `VCML_MA_SPAN);
    end
  endfunction

  // ********************************************
  // Next-state logic
  // ********************************************
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.prev = inp.clean[`VCML_KEY_W-1:0];

    // Keypad screen and edit handling
    unique case (s_r.ui)
      vcml_pkg::VCML_HOME:
      begin
        if (nav_p)
          s_nxt.ui = vcml_pkg::VCML_BROWSE;
        else if (press[`VCML_B_HAND])
        begin
          s_nxt.run  = vcml_pkg::VCML_MANUAL;
          s_nxt.disp = vcml_pkg::VCML_MANUAL;
        end
        else if (press[`VCML_B_AUTO])
          s_nxt.disp = next_auto(s_r.disp, bk_on);
        else if (press[`VCML_B_COMMIT] &&
                 s_r.disp != vcml_pkg::VCML_MANUAL &&
                 (s_r.disp != vcml_pkg::VCML_POWER_SW || bk_on))
          s_nxt.run = s_r.disp;
      end
      vcml_pkg::VCML_BROWSE:
      begin
        if (press[`VCML_B_ESC])
          s_nxt.ui = vcml_pkg::VCML_HOME;
        else if (press[`VCML_B_COMMIT])
          s_nxt.ui = vcml_pkg::VCML_EDIT;
      end
      vcml_pkg::VCML_EDIT:
      begin
        // Commit wins if both keys land together
        if (press[`VCML_B_COMMIT])
        begin
          s_nxt.cfg = vcml_pkg::vcml_cfg_t'(edit_val_i);
          s_nxt.ui  = vcml_pkg::VCML_BROWSE;
        end
        else if (press[`VCML_B_ESC])
          s_nxt.ui = vcml_pkg::VCML_BROWSE;
      end
      default:
        s_nxt.ui = vcml_pkg::VCML_HOME;
    endcase

    // Factory restore brings back the shipped settings
    if (factory_restore_i)
    begin
      s_nxt.cfg  = vcml_pkg::vcml_cfg_t'(`VCML_CFG_RST);
      s_nxt.node = `VCML_NODE_RST;
      s_nxt.baud = `VCML_BAUD_RST;
      s_nxt.tmo  = `VCML_TMO_RST;
    end

    // Target from the active mode
    s_nxt.tgt_en = 1'b1;
    s_nxt.jo     = 1'b0;
    s_nxt.jc     = 1'b0;
    unique case (s_r.run)
      vcml_pkg::VCML_MANUAL:
      begin
        s_nxt.tgt_en = 1'b0;
        s_nxt.jo = inp.clean[`VCML_B_KOPEN] & ~inp.clean[`VCML_B_KCLOSE];
        s_nxt.jc = inp.clean[`VCML_B_KCLOSE] & ~inp.clean[`VCML_B_KOPEN];
      end
      vcml_pkg::VCML_ONE_IN:
        // Configured input drives toward its own end
        s_nxt.tgt = (one_act ^ s_r.cfg.one_on_close) ?
                    `VCML_PCT_OPEN : `VCML_PCT_SHUT;
      vcml_pkg::VCML_TWO_IN:
      begin
        if (inp.clean[`VCML_B_COPEN] && !inp.clean[`VCML_B_CCLOSE])
          s_nxt.tgt = `VCML_PCT_OPEN;
        else if (inp.clean[`VCML_B_CCLOSE] && !inp.clean[`VCML_B_COPEN])
          s_nxt.tgt = `VCML_PCT_SHUT;
        else
          s_nxt.tgt_en = 1'b0;
      end
      vcml_pkg::VCML_LOOP:
        s_nxt.tgt = loop_pct(loop_cur_i);
      vcml_pkg::VCML_SERIAL, vcml_pkg::VCML_NETWORK:
        s_nxt.tgt = bus_tgt_i;
      vcml_pkg::VCML_POWER_SW:
        s_nxt.tgt = inp.clean[`VCML_B_PWR] ?
                    `VCML_PCT_OPEN : `VCML_PCT_SHUT;
      default:
        s_nxt.tgt_en = 1'b0;
    endcase

    // Override contacts take over in every mode
    if (ovr_on)
    begin
      s_nxt.tgt_en = 1'b0;
      s_nxt.jo = ~inp.clean[`VCML_B_OOPEN] & inp.clean[`VCML_B_OCLOSE];
      s_nxt.jc = ~inp.clean[`VCML_B_OCLOSE] & inp.clean[`VCML_B_OOPEN];
    end

    // Feedback current and status relays
    s_nxt.fb = `VCML_MA4 + 12'({pos_pct_i, 4'h0});
    s_nxt.rly_open  = (pos_pct_i >= s_r.cfg.open_thr) ^
                      s_r.cfg.open_break;
    s_nxt.rly_shut  = (pos_pct_i <= s_r.cfg.shut_thr) ^
                      s_r.cfg.shut_break;
    s_nxt.rly_fault = ~fault_i ^ s_r.cfg.fault_break;

    // Command field only means something in one-input mode
    if (s_r.run == vcml_pkg::VCML_ONE_IN)
      s_nxt.cmd = one_act ? vcml_pkg::VCML_CMD_ACT
                          : vcml_pkg::VCML_CMD_IDLE;
    else
      s_nxt.cmd = vcml_pkg::VCML_CMD_NONE;

    // Diagnostic counters, free running and wrapping
    s_nxt.mot_prev = motor_on_i;
    s_nxt.mot      = motor_on_i;
    if (motor_on_i && !s_r.mot_prev)
      s_nxt.starts = s_r.starts + 16'h1;
    s_nxt.ang_prev = raw_magnet_angle_i;
    s_nxt.ang_ok   = 1'b1;
    // A jump between top and bottom quarter is a wrap either way;
    // no history right after reset, so the first sample cannot wrap
    if (s_r.ang_ok &&
        ((s_r.ang_prev[11:10] == `VCML_ANG_TOP &&
          raw_magnet_angle_i[11:10] == `VCML_ANG_BOT) ||
         (s_r.ang_prev[11:10] == `VCML_ANG_BOT &&
          raw_magnet_angle_i[11:10] == `VCML_ANG_TOP)))
      s_nxt.wraps = s_r.wraps + 16'h1;
    if (motor_stall_i)
      s_nxt.mstall = s_r.mstall + 16'h1;
    if (cycle_stall_i)
      s_nxt.cstall = s_r.cstall + 16'h1;
    if (motor_stall_i || cycle_stall_i)
      s_nxt.last = cycle_num_i;
    s_nxt.cap = bk_on ? cap_lvl_i : 32'h0;
  end

  // ********************************************
  // State register
  // ********************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r      <= '0;
      s_r.ui   <= vcml_pkg::VCML_HOME;
      s_r.disp <= vcml_pkg::VCML_MANUAL;
      s_r.run  <= vcml_pkg::VCML_MANUAL;
      s_r.cfg  <= vcml_pkg::vcml_cfg_t'(`VCML_CFG_RST);
      s_r.fb   <= `VCML_MA4;
      s_r.node <= `VCML_NODE_RST;
      s_r.baud <= `VCML_BAUD_RST;
      s_r.tmo  <= `VCML_TMO_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign ui_state_o             = s_r.ui;
  assign disp_mode_o            = s_r.disp;
  assign run_mode_o             = s_r.run;
  assign cfg_o                  = s_r.cfg;
  assign tgt_pct_o              = s_r.tgt;
  assign tgt_en_o               = s_r.tgt_en;
  assign jog_open_o             = s_r.jo;
  assign jog_close_o            = s_r.jc;
  assign fb_cur_o               = s_r.fb;
  assign open_rly_o             = s_r.rly_open;
  assign shut_rly_o             = s_r.rly_shut;
  assign fault_rly_o            = s_r.rly_fault;
  assign cmd_ind_o              = s_r.cmd;
  assign node_addr_o            = s_r.node;
  assign baud_o                 = s_r.baud;
  assign timeout_s_o            = s_r.tmo;
  assign motor_energized_flag_o = s_r.mot;
  assign motor_starts_o         = s_r.starts;
  assign wrap_crossing_count_o  = s_r.wraps;
  assign motor_stall_count_o    = s_r.mstall;
  assign cycle_stall_count_o    = s_r.cstall;
  assign last_stall_cycle_o     = s_r.last;
  assign cap_lvl_o              = s_r.cap;

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_edit_commit;
    s_r.ui == vcml_pkg::VCML_EDIT && press[`VCML_B_COMMIT];
  endsequence
  sequence s_edit_cancel;
    s_r.ui == vcml_pkg::VCML_EDIT && press[`VCML_B_ESC] &&
    !press[`VCML_B_COMMIT] && !factory_restore_i;
  endsequence

  AST_ESC_HOME: assert property (
    s_r.ui == vcml_pkg::VCML_BROWSE && press[`VCML_B_ESC]
    |=> ui_state_o == 2'(vcml_pkg::VCML_HOME))
    else $error("cancel did not return home");
  AST_EDIT_STORE: assert property (
    s_edit_commit and !factory_restore_i
    |=> cfg_o == $past(edit_val_i) && ui_state_o != 2'(vcml_pkg::VCML_EDIT))
    else $error("commit did not store edit");
  AST_EDIT_DROP: assert property (
    s_edit_cancel |=> $stable(cfg_o) ##0 ui_state_o == 2'(vcml_pkg::VCML_BROWSE))
    else $error("cancel changed settings");
  AST_HAND: assert property (
    s_r.ui == vcml_pkg::VCML_HOME && !nav_p && press[`VCML_B_HAND]
    |=> run_mode_o == 3'(vcml_pkg::VCML_MANUAL) ##1 !tgt_en_o)
    else $error("hand key did not select manual");
  AST_NO_POWER: assert property (
    !bk_on && s_r.run != vcml_pkg::VCML_POWER_SW
    |=> run_mode_o != 3'(vcml_pkg::VCML_POWER_SW))
    else $error("power mode without backup");
  AST_ONE_IN: assert property (
    s_r.run == vcml_pkg::VCML_ONE_IN && !ovr_on && one_act &&
    !s_r.cfg.one_on_close |=> tgt_en_o && tgt_pct_o == `VCML_PCT_OPEN)
    else $error("one-input target wrong");
  AST_OVR: assert property (
    ovr_on && !inp.clean[`VCML_B_OOPEN] && inp.clean[`VCML_B_OCLOSE]
    |=> !tgt_en_o && jog_open_o && !jog_close_o)
    else $error("override not obeyed");
  AST_STARTS: assert property (
    $rose(motor_on_i) |=> motor_starts_o == $past(motor_starts_o) + 16'h1
    ##1 motor_energized_flag_o || !$past(motor_on_i))
    else $error("motor start not counted");
  AST_CAP_ZERO: assert property (
    !bk_on |=> cap_lvl_o == 32'h0)
    else $error("capacitor level shown without backup");
endmodule

/* File: bench/vcml_partner.sv */
`timescale 1ns/1ns
`include "vcml_defs.svh"
// ***************************************
// Keypad and field contact model
// ***************************************
module vcml_partner (
  input  wire logic [`VCML_IN_W-1:0] want_i,
  output logic [`VCML_IN_W-1:0]      pin_o
);
  // Override contacts short to common when closed, so they read low
  always_comb
  begin
    pin_o = want_i;
    pin_o[`VCML_B_OEN] = ~want_i[`VCML_B_OEN];
    pin_o[`VCML_B_OOPEN] = ~want_i[`VCML_B_OOPEN];
    pin_o[`VCML_B_OCLOSE] = ~want_i[`VCML_B_OCLOSE];
  end
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ns
`include "vcml_defs.svh"
module testbench;
  localparam int unsigned SET = 16;
  logic                   clk_sys_i;
  logic                   rst_n_i = 1'b0;
  logic [`VCML_IN_W-1:0]  w = '0;
  logic [`VCML_IN_W-1:0]  p;
  logic                   fr = 1'b0, mo = 1'b0, ms = 1'b0, cs = 1'b0;
  logic                   fi = 1'b0;
  logic [1:0]             bk = '0;
  logic [1:0]             ui, ci;
  logic [2:0]             dm, rm;
  logic [`VCML_CFG_W-1:0] ev = '0, cf;
  logic [11:0]            lc = '0, ang = '0, fb;
  logic [6:0]             pos = '0, tg;
  logic [15:0]            cn = '0, bd, st, wc, msc, csc, lsc;
  logic [7:0]             na, to;
  logic [31:0]            clo;
  logic                   te, jo, jc, orl, srl, frl, mf;
  int                     err_total = 0, num_checks = 0, cyc = 0;

  // ***************************************
  // Clock, partner and device
  // ***************************************
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  vcml_partner i_vcml_partner (.want_i(w), .pin_o(p));

  // Debounce shortened to 4 cycles to keep the run brief
  vcml_top #(.DEB_CYC(4)) i_vcml_top (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .cancel_key_i(p[`VCML_B_ESC]), .commit_key_i(p[`VCML_B_COMMIT]),
    .hand_mode_key_i(p[`VCML_B_HAND]), .auto_key_i(p[`VCML_B_AUTO]),
    .nav_key_i(p[`VCML_B_NAV]), .key_open_i(p[`VCML_B_KOPEN]),
    .key_close_i(p[`VCML_B_KCLOSE]), .cmd_open_i(p[`VCML_B_COPEN]),
    .cmd_close_i(p[`VCML_B_CCLOSE]),
    .override_enable_contact_n_i(p[`VCML_B_OEN]),
    .ovr_open_n_i(p[`VCML_B_OOPEN]), .ovr_close_n_i(p[`VCML_B_OCLOSE]),
    .power_present_i(p[`VCML_B_PWR]), .capacitor_backup_option_i(bk),
    .factory_restore_i(fr), .edit_val_i(ev), .loop_cur_i(lc),
    .bus_tgt_i(7'h00), .pos_pct_i(pos), .fault_i(fi), .motor_on_i(mo),
    .raw_magnet_angle_i(ang), .motor_stall_i(ms), .cycle_stall_i(cs),
    .cycle_num_i(cn), .cap_lvl_i(32'ha5a5a5a5), .ui_state_o(ui),
    .disp_mode_o(dm), .run_mode_o(rm), .cfg_o(cf), .tgt_pct_o(tg),
    .tgt_en_o(te), .jog_open_o(jo), .jog_close_o(jc), .fb_cur_o(fb),
    .open_rly_o(orl), .shut_rly_o(srl), .fault_rly_o(frl), .cmd_ind_o(ci),
    .node_addr_o(na), .baud_o(bd), .timeout_s_o(to),
    .motor_energized_flag_o(mf), .motor_starts_o(st),
    .wrap_crossing_count_o(wc), .motor_stall_count_o(msc),
    .cycle_stall_count_o(csc), .last_stall_cycle_o(lsc), .cap_lvl_o(clo)
  );

  // ***************************************
  // Shared tasks
  // ***************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // Wait long enough for sync plus debounce to pass the new level
  task automatic pin(input int b, input logic v);
    w[b] <= v;
    hold(SET);
  endtask

  task automatic press(input int b);
    pin(b, 1'b1);
    pin(b, 1'b0);
  endtask

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Whole run needs about 1100 cycles; the ceiling leaves wide margin
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  // ***************************************
  // Scenarios
  // ***************************************
  task automatic t_reset;
    chk(ui, 0);
    chk(cf, 32'h64);
    chk(fb, 12'h190);
    chk({na, bd, to}, 32'h0196000a);
    chk(clo, 0);
  endtask

  task automatic t_one;
    press(`VCML_B_AUTO);
    chk({dm, rm}, 6'o10);
    press(`VCML_B_COMMIT);
    chk({rm, ci}, 5'h05);
    pin(`VCML_B_COPEN, 1'b1);
    chk({te, tg, ci}, 10'h392);
    pin(`VCML_B_OEN, 1'b1);
    pin(`VCML_B_OOPEN, 1'b1);
    chk({te, jo}, 2'b01);
    pin(`VCML_B_OOPEN, 1'b0);
    pin(`VCML_B_OEN, 1'b0);
    pin(`VCML_B_COPEN, 1'b0);
    chk({te, tg, ci}, 10'h201);
  endtask

  task automatic t_loop;
    press(`VCML_B_AUTO);
    press(`VCML_B_COMMIT);
    chk(rm, 2);
    pin(`VCML_B_COPEN, 1'b1);
    chk({te, tg}, 8'he4);
    pin(`VCML_B_CCLOSE, 1'b1);
    chk(te, 0);
    pin(`VCML_B_COPEN, 1'b0);
    chk({te, tg}, 8'h80);
    pin(`VCML_B_CCLOSE, 1'b0);
    chk(te, 0);
    press(`VCML_B_AUTO);
    press(`VCML_B_COMMIT);
    chk(rm, 3);
    for (int i = 0; i < 3; i++)
    begin
      lc <= 12'(400 + 800 * i);
      hold(3);
      chk(tg, 50 * i);
    end
  endtask

  task automatic t_relay(input logic [6:0] pp, input logic [3:0] exp);
    pos <= pp;
    fi <= exp[3];
    hold(3);
    chk({fi, orl, srl, frl}, exp);
  endtask

  task automatic t_edit;
    press(`VCML_B_NAV);
    press(`VCML_B_COMMIT);
    ev <= 18'h00532;
    press(`VCML_B_ESC);
    chk({ui, cf}, {2'h1, 18'h00064});
    press(`VCML_B_COMMIT);
    press(`VCML_B_COMMIT);
    chk({ui, cf}, {2'h1, 18'h00532});
    press(`VCML_B_ESC);
    chk(ui, 0);
  endtask

  task automatic t_count;
    mo <= 1'b1;
    ang <= 12'hfff;
    hold(2);
    mo <= 1'b0;
    ang <= 12'h000;
    cn <= 16'h0005;
    ms <= 1'b1;
    hold(1);
    mo <= 1'b1;
    ms <= 1'b0;
    cn <= 16'h0007;
    cs <= 1'b1;
    hold(1);
    cs <= 1'b0;
    hold(3);
    chk({mf, st}, 17'h10002);
    chk(wc, 2);
    chk(msc, 1);
    chk({csc, lsc}, 32'h00010007);
  endtask

  // Power mode is skipped without backup, offered with it
  task automatic t_power;
    repeat (6) press(`VCML_B_AUTO);
    chk(dm, 1);
    bk <= 2'h1;
    repeat (5) press(`VCML_B_AUTO);
    chk(dm, 6);
    press(`VCML_B_COMMIT);
    chk(rm, 6);
    chk(clo, 32'ha5a5a5a5);
    chk({te, tg}, 8'h80);
    pin(`VCML_B_PWR, 1'b1);
    chk({te, tg}, 8'he4);
    pin(`VCML_B_PWR, 1'b0);
    chk({te, tg}, 8'h80);
  endtask

  initial
  begin
    hold(20);
    rst_n_i <= 1'b1;
    hold(2);
    t_reset();
    t_one();
    t_loop();
    t_relay(7'd100, 4'b0101);
    t_relay(7'd0, 4'b1010);
    pos <= 7'd50;
    hold(3);
    chk(fb, 12'h4b0);
    t_edit();
    t_relay(7'd50, 4'b0101);
    t_relay(7'd10, 4'b0011);
    fr <= 1'b1;
    hold(1);
    fr <= 1'b0;
    hold(2);
    chk(cf, 32'h64);
    t_count();
    press(`VCML_B_HAND);
    pin(`VCML_B_KOPEN, 1'b1);
    chk({rm, jo}, 4'h1);
    pin(`VCML_B_KOPEN, 1'b0);
    pin(`VCML_B_KCLOSE, 1'b1);
    chk({jo, jc}, 2'b01);
    pin(`VCML_B_KCLOSE, 1'b0);
    t_power();
    report_and_stop();
  end
endmodule
